/* File: include/reset_guard_regs.svh */
// Reset values and pin positions for the reset and serial-output guard
`ifndef RESET_GUARD_REGS_SVH
`define RESET_GUARD_REGS_SVH

// Positions inside the synchroniser vector
`define RG_PIN_EXT_RESET      0
`define RG_PIN_IO_STABLE      1
`define RG_PIN_CHIP_SELECT    2
`define RG_PIN_SDO_OVERVOLT   3
`define RG_PIN_COUNT          4

// Idle pin levels taken by the synchroniser under reset
`define RG_SYNC_RST           4'h5

// Channel defaults: low side, N-channel, output disabled
`define RG_CFG_HIGH_SIDE_RST  1'b0
`define RG_CFG_P_TYPE_RST     1'b0
`define RG_CHAN_ENABLE_RST    1'b0

// Flag reset values
`define RG_POR_FLAG_RST       1'b1
`define RG_OTHER_FLAG_RST     1'b0

`endif

/* File: include/reset_guard_pkg.sv */
// Types shared by the reset and serial-output guard
`default_nettype none
package reset_guard_pkg;

  typedef enum logic [1:0] {
    SDO_ENABLED  = 2'b00,
    SDO_TRIPPED  = 2'b01,
    SDO_WAIT_CS  = 2'b10
  } sdo_state_type;

endpackage
`default_nettype wire

/* File: include/flag_if.sv */
// Carrier between the guard and one clear-on-read event flag
`default_nettype none
interface flag_if;
  logic set;
  logic read;
  logic discard;
  logic flag;

  modport owner (output set, output read, output discard, input flag);
  modport keeper (input set, input read, input discard, output flag);
endinterface
`default_nettype wire

/* File: core/clear_on_read_flag.sv */
// Sticky event flag, cleared on read, where a new event beats the clear
`default_nettype none
module clear_on_read_flag #(
  parameter logic RESET_VALUE = 1'b0
) (
  input  wire logic sys_clk,
  input  wire logic rst_n,
  flag_if.keeper    port
);

  logic flag_reg;
  logic flag_next;

  // Set has priority so an event during the read survives it
  assign flag_next = port.set | (flag_reg & ~port.read & ~port.discard);

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      flag_reg <= RESET_VALUE;
    end else begin
      flag_reg <= flag_next;
    end
  end

  assign port.flag = flag_reg;

  set_survives_read_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    port.set |=> flag_reg) else $error("flag lost an event during a read");

endmodule
`default_nettype wire

/* File: core/reset_and_sdo_guard_ctrl.sv */
// Reset combining, channel hold-off and serial-output overvoltage guard
//
// How it works
// - Serial-output overvoltage switches the output driver off, blocking back-feed.
// - After overvoltage ends, driver returns at next chip-select rising edge, or after either reset.
// - Overvoltage flag is sticky and cleared only by a host read or either reset.
// - Below power-on release: logic reset, outputs three-state, bias and pump off.
// - Above release: logic runs, serial traffic accepted once I/O supply is stable.
// - External reset is active low and pulled up internally when unconnected.
// - Open-load detection suppressed while external reset is asserted.
// - Charge pump held off while external reset is asserted.
// - Power-on and external reset each set their own clear-on-read flag.
// - Both reset sources are ORed; full operation needs both released.
// - Leaving reset, every channel is low-side N-channel.
// - Channels stay three-stated until the host sets their enable bit.
// - Enabled outputs follow their control while no reset is active.
// - Any reset disables all outputs and drops stored diagnostic data.
// - Charge pump starts only with supply released and external reset inactive.
`default_nettype none
`include "reset_guard_regs.svh"
module reset_and_sdo_guard_ctrl
  import reset_guard_pkg::*;
#(
  parameter int CHANNELS = 8
) (
  input  wire logic                sys_clk,
  input  wire logic                rst_n,
  input  wire logic                external_reset_low,
  output logic                     external_reset_pullup_en,
  input  wire logic                io_supply_stable,
  input  wire logic                chip_select_low,
  input  wire logic                sdo_overvolt_detect,
  input  wire logic                sdo_data,
  output logic                     sdo_out,
  output logic                     sdo_oe,
  output logic                     spi_accept,
  input  wire logic                cfg_write,
  input  wire logic [CHANNELS-1:0] cfg_high_side,
  input  wire logic [CHANNELS-1:0] cfg_p_type,
  input  wire logic [CHANNELS-1:0] cfg_output_enable,
  input  wire logic [CHANNELS-1:0] channel_control,
  output logic [CHANNELS-1:0]      channel_high_side,
  output logic [CHANNELS-1:0]      channel_p_type,
  output logic [CHANNELS-1:0]      channel_output_enable,
  output logic [CHANNELS-1:0]      channel_drive,
  output logic [CHANNELS-1:0]      channel_drive_oe,
  output logic                     charge_pump_enable,
  output logic                     open_load_bias_enable,
  output logic                     open_load_detect_enable,
  output logic                     diagnostic_clear,
  input  wire logic                por_flag_read,
  input  wire logic                external_reset_flag_read,
  input  wire logic                serial_out_overvolt_flag_read,
  output logic                     por_flag,
  output logic                     external_reset_flag,
  output logic                     serial_out_overvolt_flag
);

  // Refused at elaboration: the channel vectors must fit one word
  if (CHANNELS < 1 || CHANNELS > 32) begin : g_bad_channels
    $error("CHANNELS must be 1 to 32");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers

  logic [`RG_PIN_COUNT-1:0] sync1_reg;
  logic [`RG_PIN_COUNT-1:0] sync2_reg;
  logic [`RG_PIN_COUNT-1:0] pins_raw;

  assign pins_raw = {sdo_overvolt_detect, chip_select_low,
                     io_supply_stable, external_reset_low};

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      sync1_reg <= `RG_SYNC_RST;
      sync2_reg <= `RG_SYNC_RST;
    end else begin
      sync1_reg <= pins_raw;
      sync2_reg <= sync1_reg;
    end
  end

  logic ext_reset_active;
  logic io_stable;
  logic cs_low;
  logic overvolt;

  assign ext_reset_active = ~sync2_reg[`RG_PIN_EXT_RESET];
  assign io_stable        = sync2_reg[`RG_PIN_IO_STABLE];
  assign cs_low           = sync2_reg[`RG_PIN_CHIP_SELECT];
  assign overvolt         = sync2_reg[`RG_PIN_SDO_OVERVOLT];

  ////////////////////////////////////////////////////////////////////////////
  // Chip-select edge and serial-output guard

  logic cs_prev_reg;
  logic cs_rise;
  sdo_state_type sdo_state_reg;
  sdo_state_type sdo_state_next;

  // Rising edge of the pin means the frame has ended
  assign cs_rise = cs_low & ~cs_prev_reg;

  always_comb begin
    sdo_state_next = sdo_state_reg;
    case (sdo_state_reg)
      SDO_ENABLED: begin
        if (overvolt) begin
          sdo_state_next = SDO_TRIPPED;
        end
      end
      SDO_TRIPPED: begin
        if (!overvolt) begin
          sdo_state_next = SDO_WAIT_CS;
        end
      end
      SDO_WAIT_CS: begin
        if (overvolt) begin
          sdo_state_next = SDO_TRIPPED;
        end else if (cs_rise) begin
          sdo_state_next = SDO_ENABLED;
        end
      end
      default: begin
        sdo_state_next = SDO_TRIPPED;
      end
    endcase
  end

  logic sdo_oe_next;
  logic spi_accept_next;

  // Overvoltage is gated here too: the state lags it by a cycle
  assign spi_accept_next = io_stable & ~ext_reset_active;
  assign sdo_oe_next     = spi_accept_next & ~cs_low & ~overvolt
                         & (sdo_state_reg == SDO_ENABLED);

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cs_prev_reg   <= 1'b1;
      sdo_state_reg <= SDO_ENABLED;
      sdo_oe        <= 1'b0;
      sdo_out       <= 1'b0;
      spi_accept    <= 1'b0;
    end else begin
      cs_prev_reg   <= cs_low;
      sdo_state_reg <= ext_reset_active ? SDO_ENABLED : sdo_state_next;
      sdo_oe        <= sdo_oe_next;
      sdo_out       <= sdo_data & sdo_oe_next;
      spi_accept    <= spi_accept_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Channel configuration and output stage

  logic [CHANNELS-1:0] drive_oe_next;

  // Synchronised external reset adds two cycles before outputs drop
  assign drive_oe_next = channel_output_enable & {CHANNELS{~ext_reset_active}};

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      channel_high_side     <= {CHANNELS{`RG_CFG_HIGH_SIDE_RST}};
      channel_p_type        <= {CHANNELS{`RG_CFG_P_TYPE_RST}};
      channel_output_enable <= {CHANNELS{`RG_CHAN_ENABLE_RST}};
    end else if (ext_reset_active) begin
      channel_high_side     <= {CHANNELS{`RG_CFG_HIGH_SIDE_RST}};
      channel_p_type        <= {CHANNELS{`RG_CFG_P_TYPE_RST}};
      channel_output_enable <= {CHANNELS{`RG_CHAN_ENABLE_RST}};
    end else if (cfg_write) begin
      channel_high_side     <= cfg_high_side;
      channel_p_type        <= cfg_p_type;
      channel_output_enable <= cfg_output_enable;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      channel_drive_oe <= '0;
      channel_drive    <= '0;
    end else begin
      channel_drive_oe <= drive_oe_next;
      channel_drive    <= channel_control & drive_oe_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Charge pump, open-load bias and diagnostics

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      charge_pump_enable       <= 1'b0;
      open_load_bias_enable    <= 1'b0;
      open_load_detect_enable  <= 1'b0;
      diagnostic_clear         <= 1'b1;
      external_reset_pullup_en <= 1'b1;
    end else begin
      charge_pump_enable       <= ~ext_reset_active;
      open_load_bias_enable    <= 1'b1;
      open_load_detect_enable  <= ~ext_reset_active;
      diagnostic_clear         <= ext_reset_active;
      external_reset_pullup_en <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Event flags

  flag_if por_port ();
  flag_if ext_port ();
  flag_if ov_port ();

  // Power-on flag comes up set by the reset itself
  assign por_port.set     = 1'b0;
  assign por_port.read    = por_flag_read;
  assign por_port.discard = 1'b0;
  assign ext_port.set     = ext_reset_active;
  assign ext_port.read    = external_reset_flag_read;
  assign ext_port.discard = 1'b0;
  assign ov_port.set      = overvolt;
  assign ov_port.read     = serial_out_overvolt_flag_read;
  assign ov_port.discard  = ext_reset_active;

  clear_on_read_flag #(.RESET_VALUE(`RG_POR_FLAG_RST)) por_flag_u (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .port    (por_port.keeper)
  );

  clear_on_read_flag #(.RESET_VALUE(`RG_OTHER_FLAG_RST)) ext_flag_u (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .port    (ext_port.keeper)
  );

  clear_on_read_flag #(.RESET_VALUE(`RG_OTHER_FLAG_RST)) ov_flag_u (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .port    (ov_port.keeper)
  );

  assign por_flag                 = por_port.flag;
  assign external_reset_flag      = ext_port.flag;
  assign serial_out_overvolt_flag = ov_port.flag;

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  sdo_off_overvolt_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    overvolt |=> !sdo_oe) else $error("serial output driven during overvoltage");

  sdo_wait_edge_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (sdo_state_reg == SDO_WAIT_CS) && !cs_rise && !ext_reset_active
      |=> (sdo_state_reg != SDO_ENABLED))
    else $error("serial output re-enabled without chip-select edge");

  ov_flag_sticky_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    serial_out_overvolt_flag && !serial_out_overvolt_flag_read && !ext_reset_active
      |=> serial_out_overvolt_flag) else $error("overvolt flag dropped without read");

  spi_accept_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    io_stable && !ext_reset_active |=> spi_accept)
    else $error("serial traffic refused with supplies good");

  open_load_off_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    ext_reset_active |=> !open_load_detect_enable)
    else $error("open-load detection active in external reset");

  pump_off_reset_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    ext_reset_active |=> !charge_pump_enable)
    else $error("charge pump on in external reset");

  ext_flag_set_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    ext_reset_active |=> external_reset_flag) else $error("external reset not flagged");

  default_config_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    ext_reset_active |=> (channel_high_side == '0) && (channel_p_type == '0))
    else $error("channel config not default after reset");

  stay_tristate_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !channel_output_enable[0] |=> !channel_drive_oe[0])
    else $error("channel driven without enable");

  follow_control_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    channel_output_enable[0] && !ext_reset_active
      |=> channel_drive[0] == $past(channel_control[0]))
    else $error("enabled channel not following control");

  reset_drops_all_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    ext_reset_active ##1 ext_reset_active |=> (channel_drive_oe == '0) && !sdo_oe)
    else $error("outputs still enabled in reset");

endmodule
`default_nettype wire

/* File: test/host_model.sv */
// Host-side model: reset line and chip select toward the guard
`default_nettype none
module host_model (
  input  wire logic hold_reset,
  input  wire logic frame,
  input  wire logic pullup_en,
  output logic      external_reset_low,
  output logic      chip_select_low
);
  timeunit 1ns;
  timeprecision 1ps;
  // A released reset line settles at the pull-up level, never floats
  assign external_reset_low = hold_reset ? 1'h0 : pullup_en;
  assign chip_select_low    = ~frame;
endmodule
`default_nettype wire

/* File: test/tb_reset_and_sdo_guard_ctrl.sv */
// Self-checking bench for the reset and serial-output guard
`default_nettype none
module tb_reset_and_sdo_guard_ctrl;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int CH = 8;
  logic          sys_clk = 1'h0;
  logic          rst_n = 1'h0;
  logic          hold_reset = 1'h0;
  logic          frame = 1'h0;
  logic          io_stable = 1'h1;
  logic          ov = 1'h0;
  logic          sdo_data = 1'h1;
  logic          cfg_write = 1'h0;
  logic [CH-1:0] oe = 8'h00;
  logic [CH-1:0] ctl = 8'ha5;
  logic [CH-1:0] hs = 8'h00;
  logic [CH-1:0] pt = 8'h00;
  logic          rd_por = 1'h0;
  logic          rd_ext = 1'h0;
  logic          rd_ov = 1'h0;
  logic          ext_low, cs_low, pullup_en, sdo_out, sdo_oe, spi_accept;
  logic [CH-1:0] ch_hs, ch_pt, ch_oe, ch_drv, ch_drv_oe;
  logic          cp_en, olb_en, old_en, diag_clr, por_f, ext_f, ov_f;
  int            fail_count = 0;
  int            n_tests = 0;
  int            cycles = 0;

  always #5 sys_clk = ~sys_clk;

  host_model u_host_model (.hold_reset(hold_reset), .frame(frame), .pullup_en(pullup_en),
    .external_reset_low(ext_low), .chip_select_low(cs_low));

  reset_and_sdo_guard_ctrl #(.CHANNELS(CH)) u_reset_and_sdo_guard_ctrl (
    .sys_clk(sys_clk), .rst_n(rst_n), .external_reset_low(ext_low),
    .external_reset_pullup_en(pullup_en), .io_supply_stable(io_stable),
    .chip_select_low(cs_low), .sdo_overvolt_detect(ov), .sdo_data(sdo_data),
    .sdo_out(sdo_out), .sdo_oe(sdo_oe), .spi_accept(spi_accept), .cfg_write(cfg_write),
    .cfg_high_side(hs), .cfg_p_type(pt), .cfg_output_enable(oe),
    .channel_control(ctl), .channel_high_side(ch_hs), .channel_p_type(ch_pt),
    .channel_output_enable(ch_oe), .channel_drive(ch_drv), .channel_drive_oe(ch_drv_oe),
    .charge_pump_enable(cp_en), .open_load_bias_enable(olb_en),
    .open_load_detect_enable(old_en), .diagnostic_clear(diag_clr),
    .por_flag_read(rd_por), .external_reset_flag_read(rd_ext),
    .serial_out_overvolt_flag_read(rd_ov), .por_flag(por_f),
    .external_reset_flag(ext_f), .serial_out_overvolt_flag(ov_f));

  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // Pins pass two flops, so four cycles covers every pin-driven effect
  task automatic cyc(input int n);
    repeat (n) @(negedge sys_clk);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_power_reset();
    rst_n = 1'h0;
    cyc(1);
    check("por_flag", por_f, 1'h1);
    check("chan_oe", ch_drv_oe, 8'h00);
    check("pump", cp_en, 1'h0);
    check("ol_bias", olb_en, 1'h0);
    check("diag_clr", diag_clr, 1'h1);
    check("sdo_oe", sdo_oe, 1'h0);
    rst_n = 1'h1;
    cyc(4);
    check("hs_default", ch_hs, 8'h00);
    check("p_default", ch_pt, 8'h00);
    check("ena_default", ch_oe, 8'h00);
    check("pump_on", cp_en, 1'h1);
    check("accept", spi_accept, 1'h1);
    check("pullup", pullup_en, 1'h1);
    check("ol_bias_on", olb_en, 1'h1);
    rd_por = 1'h1;
    cyc(1);
    rd_por = 1'h0;
    check("por_clr", por_f, 1'h0);
  endtask

  task automatic t_drive();
    // Non-default side and type so a later reset has something to undo
    ctl = 8'ha5;
    hs = 8'h0f;
    pt = 8'h05;
    oe = 8'h3c;
    cfg_write = 1'h1;
    cyc(1);
    cfg_write = 1'h0;
    cyc(2);
    check("hs", ch_hs, 8'h0f);
    check("pt", ch_pt, 8'h05);
    check("ena", ch_oe, 8'h3c);
    check("drv_oe", ch_drv_oe, 8'h3c);
    check("drv", ch_drv, 8'h24);
    ctl = 8'hff;
    cyc(2);
    check("drv_follow", ch_drv, 8'h3c);
  endtask

  task automatic t_ext_reset();
    hold_reset = 1'h1;
    cyc(4);
    check("ext_pump", cp_en, 1'h0);
    check("ext_ol", old_en, 1'h0);
    check("ext_drv_oe", ch_drv_oe, 8'h00);
    check("ext_ena", ch_oe, 8'h00);
    check("ext_pt", ch_pt, 8'h00);
    check("ext_diag", diag_clr, 1'h1);
    check("ext_flag", ext_f, 1'h1);
    check("ext_accept", spi_accept, 1'h0);
    hold_reset = 1'h0;
    cyc(4);
    check("rel_pump", cp_en, 1'h1);
    check("rel_ol", old_en, 1'h1);
    check("rel_hs", ch_hs, 8'h00);
    check("rel_pt", ch_pt, 8'h00);
    check("rel_diag", diag_clr, 1'h0);
    check("flag_held", ext_f, 1'h1);
    rd_ext = 1'h1;
    cyc(1);
    rd_ext = 1'h0;
    check("ext_clr", ext_f, 1'h0);
  endtask

  task automatic t_sdo_guard();
    frame = 1'h1;
    cyc(4);
    check("sdo_on", sdo_oe, 1'h1);
    check("sdo_data", sdo_out, 1'h1);
    sdo_data = 1'h0;
    cyc(1);
    check("sdo_low", sdo_out, 1'h0);
    sdo_data = 1'h1;
    ov = 1'h1;
    cyc(4);
    check("ov_off", sdo_oe, 1'h0);
    check("ov_out", sdo_out, 1'h0);
    check("ov_flag", ov_f, 1'h1);
    rd_ov = 1'h1;
    cyc(1);
    rd_ov = 1'h0;
    check("ov_rd_live", ov_f, 1'h1);
    ov = 1'h0;
    cyc(4);
    check("ov_still_off", sdo_oe, 1'h0);
    check("ov_sticky", ov_f, 1'h1);
    frame = 1'h0;
    cyc(4);
    frame = 1'h1;
    cyc(4);
    check("ov_back", sdo_oe, 1'h1);
    rd_ov = 1'h1;
    cyc(1);
    rd_ov = 1'h0;
    check("ov_clr", ov_f, 1'h0);
    io_stable = 1'h0;
    cyc(4);
    check("io_unstable", spi_accept, 1'h0);
    io_stable = 1'h1;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  always @(posedge sys_clk) begin
    cycles++;
    // Whole run needs about 60 cycles
    if (cycles == 3000) begin
      fail_count++;
      wrap_up();
    end
  end

  initial begin
    cyc(2);
    t_power_reset();
    t_drive();
    t_ext_reset();
    t_sdo_guard();
    t_drive();
    t_power_reset();
    wrap_up();
  end
endmodule
`default_nettype wire
